// ---- core/rx_path_cfg_regs.sv ----
// receive-path configuration register bank with decoded settings
`timescale 1ns/1ps
`include "rx_cfg_defines.svh"
module rx_path_cfg_regs #(
    parameter logic [3:0] FACTORY_TRIM = 4'h0,
    parameter logic [2:0] FACTORY_SLOPE = 3'h0,
    parameter logic [3:0] FACTORY_INTERCEPT = 4'h0
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire rx_cfg_pkg::reg_addr_t reg_addr,
    input wire rx_cfg_pkg::reg_byte_t reg_wdata,
    output rx_cfg_pkg::reg_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire logic highpass_select,
    input wire logic trim_override_enable,
    input wire logic [5:0] filter_frequency_code,
    output rx_cfg_pkg::freq_code_t effective_freq_code,
    output logic quality_active,
    output rx_cfg_pkg::q_value_t quality_value,
    output rx_cfg_pkg::nibble_t slope_code,
    output rx_cfg_pkg::nibble_t intercept_code,
    output rx_cfg_pkg::gain_x2_t preamp_gain_x2,
    output logic scale_5v_select,
    output logic first_stage_enable,
    output logic last_stage_enable,
    output rx_cfg_pkg::reg_byte_t device_control_three
);
    rx_cfg_pkg::reg_byte_t fqt_reg, fqt_next;
    rx_cfg_pkg::reg_byte_t laa_reg, laa_next;
    rx_cfg_pkg::reg_byte_t gsc_reg, gsc_next;
    rx_cfg_pkg::reg_byte_t dc3_reg, dc3_next;
    rx_cfg_pkg::reg_byte_t rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    rx_cfg_pkg::freq_code_t freq_reg, freq_next;
    logic qact_reg, qact_next;
    rx_cfg_pkg::q_value_t qval_reg, qval_next;
    rx_cfg_pkg::nibble_t slope_reg, slope_next;
    rx_cfg_pkg::nibble_t icpt_reg, icpt_next;
    rx_cfg_pkg::gain_x2_t gain_reg, gain_next;

    rx_cfg_if cfg ();

    assign cfg.freq_code = filter_frequency_code;
    assign cfg.highpass = highpass_select;
    assign cfg.trim_ovr = trim_override_enable;
    assign cfg.trim = fqt_reg[`RX_TRIM_MSB:`RX_TRIM_LSB];
    assign cfg.q_sel = fqt_reg[`RX_QSEL_MSB:`RX_QSEL_LSB];
    assign cfg.amp_ovr = laa_reg[`RX_AMP_OVR_BIT];
    assign cfg.slope = laa_reg[`RX_SLOPE_MSB:`RX_SLOPE_LSB];
    assign cfg.intercept = laa_reg[`RX_INTERCEPT_MSB:`RX_INTERCEPT_LSB];
    assign cfg.scale = gsc_reg[`RX_SCALE_BIT];
    assign cfg.gain_sel = gsc_reg[`RX_GAIN_MSB:`RX_GAIN_LSB];

    rx_setting_decode #(
        .FACTORY_TRIM(FACTORY_TRIM),
        .FACTORY_SLOPE(FACTORY_SLOPE),
        .FACTORY_INTERCEPT(FACTORY_INTERCEPT)
    ) u_decode (
        .cfg(cfg)
    );

    // register file: write decode, masked storage, registered read
    always_comb begin
        fqt_next = fqt_reg;
        laa_next = laa_reg;
        gsc_next = gsc_reg;
        dc3_next = dc3_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                // read-only reserved bits never store
                `RX_ADDR_FILTER_QUALITY_TRIM:
                    fqt_next = reg_wdata & `RX_MASK_FILTER_QUALITY_TRIM;
                `RX_ADDR_LOG_AMP_ADJUST:
                    laa_next = reg_wdata & `RX_MASK_LOG_AMP_ADJUST;
                `RX_ADDR_GAIN_SCALING_CTRL:
                    gsc_next = reg_wdata & `RX_MASK_GAIN_SCALING_CTRL;
                `RX_ADDR_DEVICE_CTRL_THREE:
                    dc3_next = reg_wdata & `RX_MASK_DEVICE_CTRL_THREE;
                default: ;
            endcase
        end
        if (reg_rd) begin
            rvalid_next = 1'b1;
            // unmapped addresses read zero, not stale data
            case (reg_addr)
                `RX_ADDR_FILTER_QUALITY_TRIM: rdata_next = fqt_reg;
                `RX_ADDR_LOG_AMP_ADJUST: rdata_next = laa_reg;
                `RX_ADDR_GAIN_SCALING_CTRL: rdata_next = gsc_reg;
                `RX_ADDR_DEVICE_CTRL_THREE: rdata_next = dc3_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fqt_reg <= `RX_RESET_FILTER_QUALITY_TRIM;
            laa_reg <= `RX_RESET_LOG_AMP_ADJUST;
            gsc_reg <= `RX_RESET_GAIN_SCALING_CTRL;
            dc3_reg <= `RX_RESET_DEVICE_CTRL_THREE;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else if (clk_en) begin
            fqt_reg <= fqt_next;
            laa_reg <= laa_next;
            gsc_reg <= gsc_next;
            dc3_reg <= dc3_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // decoded settings registered so analog controls change glitch-free
    always_comb begin
        freq_next = cfg.eff_freq;
        qact_next = cfg.q_active;
        qval_next = cfg.q_value;
        slope_next = cfg.eff_slope_code;
        icpt_next = cfg.eff_intercept;
        gain_next = cfg.gain_x2;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            freq_reg <= 7'h00;
            qact_reg <= 1'b1;
            qval_reg <= 3'h4;
            slope_reg <= 4'h0;
            icpt_reg <= 4'h0;
            gain_reg <= 6'h1E;
        end else if (clk_en) begin
            freq_reg <= freq_next;
            qact_reg <= qact_next;
            qval_reg <= qval_next;
            slope_reg <= slope_next;
            icpt_reg <= icpt_next;
            gain_reg <= gain_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign effective_freq_code = freq_reg;
    assign quality_active = qact_reg;
    assign quality_value = qval_reg;
    assign slope_code = slope_reg;
    assign intercept_code = icpt_reg;
    assign preamp_gain_x2 = gain_reg;
    assign scale_5v_select = gsc_reg[`RX_SCALE_BIT];
    assign first_stage_enable = ~gsc_reg[`RX_FIRST_DIS_BIT];
    assign last_stage_enable = ~gsc_reg[`RX_LAST_DIS_BIT];
    assign device_control_three = dc3_reg;

    chk_write_readback: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == `RX_ADDR_LOG_AMP_ADJUST && !reg_rd
        ##1 clk_en && reg_rd && reg_addr == `RX_ADDR_LOG_AMP_ADJUST
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
        else $error("readback differs from written value");

    chk_reserved_zero: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        fqt_reg[7:6] == 2'h0 && gsc_reg[3] == 1'b0)
        else $error("read-only reserved bit became set");

    chk_quality_gate: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en |=> quality_active == !$past(highpass_select))
        else $error("quality active does not follow filter path");

    chk_quality_map: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && fqt_reg[5:4] == 2'h2 |=> quality_value == 3'h2)
        else $error("quality code two did not give Q of two");

    chk_trim_sum: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && trim_override_enable
        |=> effective_freq_code == {1'b0, $past(filter_frequency_code)}
            + {3'h0, $past(fqt_reg[3:0])})
        else $error("trim not added to frequency code");

    chk_factory_trim: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && !trim_override_enable
        |=> effective_freq_code == {1'b0, $past(filter_frequency_code)}
            + {3'h0, FACTORY_TRIM})
        else $error("factory trim not used without override");

    chk_amp_factory: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && !laa_reg[7] |=> intercept_code == FACTORY_INTERCEPT
            && slope_code[2:0] == FACTORY_SLOPE)
        else $error("factory amplifier values not used");

    chk_slope_scale: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && laa_reg[7]
        |=> slope_code == {$past(gsc_reg[2]), $past(laa_reg[6:4])})
        else $error("slope code not paired with scaling");

    chk_stage_disable: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == `RX_ADDR_GAIN_SCALING_CTRL
        |=> first_stage_enable == !$past(reg_wdata[7])
            && last_stage_enable == !$past(reg_wdata[6]))
        else $error("stage enable does not follow write");

    chk_gain_map: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        clk_en && gsc_reg[1:0] == 2'h3 |=> preamp_gain_x2 == 6'h19)
        else $error("gain code three did not give 12.5");

    chk_freeze_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !clk_en |=> $stable(fqt_reg) && $stable(gsc_reg)
            && $stable(reg_rvalid))
        else $error("state moved while clock enable low");
endmodule : rx_path_cfg_regs

// ---- inc/rx_cfg_defines.svh ----
// offsets, field positions, masks and reset values of the receive-path bank
`ifndef RX_CFG_DEFINES_SVH
`define RX_CFG_DEFINES_SVH

`define RX_ADDR_FILTER_QUALITY_TRIM 6'h11
`define RX_ADDR_LOG_AMP_ADJUST 6'h12
`define RX_ADDR_GAIN_SCALING_CTRL 6'h13
`define RX_ADDR_DEVICE_CTRL_THREE 6'h14

`define RX_RESET_FILTER_QUALITY_TRIM 8'h00
`define RX_RESET_LOG_AMP_ADJUST 8'h00
`define RX_RESET_GAIN_SCALING_CTRL 8'h00
`define RX_RESET_DEVICE_CTRL_THREE 8'h00

`define RX_MASK_FILTER_QUALITY_TRIM 8'h3F
`define RX_MASK_LOG_AMP_ADJUST 8'hFF
`define RX_MASK_GAIN_SCALING_CTRL 8'hF7
`define RX_MASK_DEVICE_CTRL_THREE 8'hFF

`define RX_QSEL_MSB 5
`define RX_QSEL_LSB 4
`define RX_TRIM_MSB 3
`define RX_TRIM_LSB 0
`define RX_AMP_OVR_BIT 7
`define RX_SLOPE_MSB 6
`define RX_SLOPE_LSB 4
`define RX_INTERCEPT_MSB 3
`define RX_INTERCEPT_LSB 0
`define RX_FIRST_DIS_BIT 7
`define RX_LAST_DIS_BIT 6
`define RX_SCALE_BIT 2
`define RX_GAIN_MSB 1
`define RX_GAIN_LSB 0

`endif

// ---- inc/rx_cfg_pkg.sv ----
// types shared by the receive-path configuration bank
package rx_cfg_pkg;
    typedef logic [5:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [6:0] freq_code_t;
    typedef logic [3:0] nibble_t;
    typedef logic [2:0] q_value_t;
    typedef logic [5:0] gain_x2_t;
endpackage : rx_cfg_pkg

// ---- inc/rx_cfg_if.sv ----
// register fields out to the decoder and decoded settings back
`timescale 1ns/1ps
interface rx_cfg_if;
    logic [5:0] freq_code;
    logic highpass;
    logic trim_ovr;
    rx_cfg_pkg::nibble_t trim;
    logic [1:0] q_sel;
    logic amp_ovr;
    logic [2:0] slope;
    rx_cfg_pkg::nibble_t intercept;
    logic scale;
    logic [1:0] gain_sel;
    rx_cfg_pkg::freq_code_t eff_freq;
    logic q_active;
    rx_cfg_pkg::q_value_t q_value;
    rx_cfg_pkg::nibble_t eff_slope_code;
    rx_cfg_pkg::nibble_t eff_intercept;
    rx_cfg_pkg::gain_x2_t gain_x2;
    modport bank (output freq_code, highpass, trim_ovr, trim, q_sel, amp_ovr,
        slope, intercept, scale, gain_sel, input eff_freq, q_active, q_value,
        eff_slope_code, eff_intercept, gain_x2);
    modport dec (input freq_code, highpass, trim_ovr, trim, q_sel, amp_ovr,
        slope, intercept, scale, gain_sel, output eff_freq, q_active, q_value,
        eff_slope_code, eff_intercept, gain_x2);
endinterface : rx_cfg_if

// ---- core/rx_setting_decode.sv ----
// combinational decode of register fields into effective analog settings
`timescale 1ns/1ps
module rx_setting_decode #(
    parameter logic [3:0] FACTORY_TRIM = 4'h0,
    parameter logic [2:0] FACTORY_SLOPE = 3'h0,
    parameter logic [3:0] FACTORY_INTERCEPT = 4'h0
) (
    rx_cfg_if.dec cfg
);
    rx_cfg_pkg::nibble_t trim_used;

    always_comb begin
        // factory trim unless the override is set
        trim_used = cfg.trim_ovr ? cfg.trim : FACTORY_TRIM;
        // sum kept one bit wider so a large trim cannot wrap
        cfg.eff_freq = {1'b0, cfg.freq_code} + {3'h0, trim_used};
        // quality only meaningful on the bandpass path
        cfg.q_active = ~cfg.highpass;
        case (cfg.q_sel)
            2'h0: cfg.q_value = 3'h4;
            2'h1: cfg.q_value = 3'h5;
            2'h2: cfg.q_value = 3'h2;
            default: cfg.q_value = 3'h3;
        endcase
        // slope meaning depends on output scaling
        cfg.eff_slope_code = {cfg.scale,
            cfg.amp_ovr ? cfg.slope : FACTORY_SLOPE};
        cfg.eff_intercept = cfg.amp_ovr ? cfg.intercept
                                        : FACTORY_INTERCEPT;
        // gain in half-steps so 12.5 stays an integer
        case (cfg.gain_sel)
            2'h0: cfg.gain_x2 = 6'h1E;
            2'h1: cfg.gain_x2 = 6'h14;
            2'h2: cfg.gain_x2 = 6'h28;
            default: cfg.gain_x2 = 6'h19;
        endcase
    end
endmodule : rx_setting_decode

// ---- verif/host_model.sv ----
// host-side master that issues single-byte register accesses
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output rx_cfg_pkg::reg_addr_t reg_addr,
    output rx_cfg_pkg::reg_byte_t reg_wdata,
    input wire rx_cfg_pkg::reg_byte_t reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end
    // released bus is inverted so a stale value never looks valid
    task automatic wr(input rx_cfg_pkg::reg_addr_t a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input rx_cfg_pkg::reg_addr_t a, output logic [7:0] d,
        output logic ok);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        ok = reg_rvalid;
    endtask : rd
    // write then read the same address on the very next enabled edge
    task automatic wr_rd(input rx_cfg_pkg::reg_addr_t a, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata;
        ok = reg_rvalid;
    endtask : wr_rd
endmodule : host_model

// ---- verif/rx_path_cfg_regs_tb_top.sv ----
// self-checking bench for the receive-path configuration bank
`timescale 1ns/1ps
module rx_path_cfg_regs_tb_top;
    localparam logic [3:0] F_TRIM = 4'h5;
    localparam logic [2:0] F_SLOPE = 3'h3;
    localparam logic [3:0] F_INT = 4'hA;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, quality_active, scale_5v_select;
    logic first_stage_enable, last_stage_enable;
    rx_cfg_pkg::reg_addr_t reg_addr;
    rx_cfg_pkg::reg_byte_t reg_wdata, reg_rdata, device_control_three;
    logic highpass_select = 1'b0;
    logic trim_override_enable = 1'b0;
    logic [5:0] filter_frequency_code = 6'h00;
    rx_cfg_pkg::freq_code_t effective_freq_code;
    rx_cfg_pkg::q_value_t quality_value;
    rx_cfg_pkg::nibble_t slope_code, intercept_code;
    rx_cfg_pkg::gain_x2_t preamp_gain_x2;
    int mismatches = 0;
    int checked = 0;
    int seed = 64;
    logic [7:0] mdl [4];
    logic [7:0] wmask [4] = '{8'h3F, 8'hFF, 8'hF7, 8'hFF};
    always #50 core_clk = ~core_clk;
    // nonzero factory values so the override mux is really exercised
    rx_path_cfg_regs #(.FACTORY_TRIM(F_TRIM), .FACTORY_SLOPE(F_SLOPE),
        .FACTORY_INTERCEPT(F_INT)) uut (.core_clk, .arst_n, .clk_en,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .highpass_select, .trim_override_enable, .filter_frequency_code,
        .effective_freq_code, .quality_active, .quality_value, .slope_code,
        .intercept_code, .preamp_gain_x2, .scale_5v_select,
        .first_stage_enable, .last_stage_enable, .device_control_three);
    host_model host (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid);
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd_chk(input rx_cfg_pkg::reg_addr_t a);
        logic [7:0] d;
        logic ok;
        logic [7:0] e;
        e = (a >= 6'h11 && a <= 6'h14) ? mdl[a - 6'h11] : 8'h00;
        host.rd(a, d, ok);
        cmp(8'(ok), 8'h01);
        cmp(d, e);
    endtask : rd_chk
    task automatic b2b_chk(input rx_cfg_pkg::reg_addr_t a);
        logic [7:0] d;
        logic [7:0] q;
        logic ok;
        d = 8'($random(seed));
        host.wr_rd(a, d, q, ok);
        mdl[a - 6'h11] = d & wmask[a - 6'h11];
        cmp(8'(ok), 8'h01);
        cmp(q, mdl[a - 6'h11]);
    endtask : b2b_chk
    task automatic wr_m(input rx_cfg_pkg::reg_addr_t a, input logic [7:0] d);
        host.wr(a, d);
        if (a >= 6'h11 && a <= 6'h14) begin
            mdl[a - 6'h11] = d & wmask[a - 6'h11];
        end
    endtask : wr_m
    task automatic dec_chk;
        int q [4] = '{4, 5, 2, 3};
        int g [4] = '{30, 20, 40, 25};
        logic [7:0] r1, r2, r3;
        r1 = mdl[0];
        r2 = mdl[1];
        r3 = mdl[2];
        {highpass_select, trim_override_enable, filter_frequency_code} =
            8'($random(seed));
        repeat (2) @(negedge core_clk);
        cmp(8'(effective_freq_code), 8'(filter_frequency_code) +
            8'(trim_override_enable ? r1[3:0] : F_TRIM));
        cmp(8'(quality_active), 8'(!highpass_select));
        if (!highpass_select) begin
            cmp(8'(quality_value), 8'(q[r1[5:4]]));
        end
        cmp(8'(slope_code), {4'h0, r3[2],
            r2[7] ? r2[6:4] : F_SLOPE});
        cmp(8'(intercept_code), 8'(r2[7] ? r2[3:0] : F_INT));
        cmp(8'(preamp_gain_x2), 8'(g[r3[1:0]]));
        cmp({5'h0, scale_5v_select, first_stage_enable, last_stage_enable},
            {5'h0, r3[2], !r3[7], !r3[6]});
        cmp(device_control_three, mdl[3]);
    endtask : dec_chk
    task automatic do_reset;
        arst_n = 1'b0;
        repeat (8) @(negedge core_clk);
        arst_n = 1'b1;
        foreach (mdl[i]) mdl[i] = 8'h00;
        for (int a = 'h10; a <= 'h15; a++) rd_chk(6'(a));
        dec_chk();
        $display("test reset_values done");
    endtask : do_reset
    initial begin
        do_reset();
        for (int i = 0; i < 8; i++) begin
            wr_m(6'h11, 8'(i * 8'h55));
            wr_m(6'h12, 8'(i * 8'h91));
            wr_m(6'h13, 8'(i * 8'h25));
            wr_m(6'h14, 8'(i * 8'h3B));
            wr_m(6'h15, 8'hFF);
            for (int a = 'h10; a <= 'h15; a++) rd_chk(6'(a));
            dec_chk();
        end
        $display("test code_tables done");
        for (int i = 0; i < 24; i++) begin
            wr_m(6'(6'h10 + $unsigned($random(seed)) % 6), 8'($random(seed)));
            rd_chk(6'h11 + 6'(i % 4));
            dec_chk();
        end
        $display("test random_access done");
        // readback in the cycle right after the write, no idle gap
        for (int i = 0; i < 8; i++) begin
            b2b_chk(6'h11 + 6'(i % 4));
        end
        $display("test back_to_back done");
        // writes while the enable is low must leave the bank frozen
        clk_en = 1'b0;
        host.wr(6'h14, ~mdl[3]);
        clk_en = 1'b1;
        rd_chk(6'h14);
        $display("test clock_enable done");
        do_reset();
        end_of_test();
    end
    initial begin
        #(100 * 20000);
        mismatches++;
        end_of_test();
    end
endmodule : rx_path_cfg_regs_tb_top
